// File: common/logic_unit_pkg.sv
// Purpose: shared constants and carriers for the logic unit flag and function-select block
// Assumes: 8-bit special-function-register port of the core, one system clock
// Notes: offsets are the core's register addresses inside the block's page
package logic_unit_pkg;

  localparam int UNIT_COUNT = 4;
  localparam int SOURCE_COUNT = 16;

  // Register page and addresses
  localparam logic [7:0] REG_PAGE = 8'h20;
  localparam logic [7:0] UNIT0_INPUT_SELECT_ADDR = 8'h84;
  localparam logic [7:0] UNIT0_TRUTH_TABLE_ADDR = 8'haf;
  localparam logic [7:0] OUTPUT_STATE_ADDR = 8'hd1;
  localparam logic [7:0] EDGE_FLAG_ADDR = 8'he8;

  // Bit addresses of the bit-addressable flag register share its upper five bits
  localparam int BIT_GROUP_LSB = 3;
  localparam logic [4:0] EDGE_FLAG_BIT_GROUP = 5'h1d;

  // Field positions
  localparam int INPUT_A_LSB = 4;
  localparam int INPUT_B_LSB = 0;
  localparam int SELECT_WIDTH = 4;
  localparam int RISING_FLAG_OFFSET = 1;
  localparam int FALLING_FLAG_OFFSET = 0;
  localparam int FLAGS_PER_UNIT = 2;

  // Reset values
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] TRUTH_TABLE_RESET = 8'h00;
  localparam logic [7:0] EDGE_FLAG_RESET = 8'h00;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

  // Synchroniser depth in front of the edge detectors
  localparam int SYNC_STAGES = 2;

  // One access from the core: byte read or write, or single-bit read or write
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [7:0] bit_addr;
    logic bit_value;
    logic bit_we;
    logic bit_re;
  } sfr_req_type;

  // Answer to a read, one cycle after the request
  typedef struct packed {
    logic [7:0] rdata;
    logic rbit;
    logic rvalid;
  } sfr_rsp_type;

endpackage

// File: hw/unit_edge_sense.sv
// Purpose: resynchronise the unit outputs and find their edges on the system clock
// Assumes: unit outputs are asynchronous to core_clk
// Notes: rise and fall are one-cycle pulses aligned with the synchronised level
`timescale 1ns/1ps
module unit_edge_sense #(
  parameter int UNITS = logic_unit_pkg::UNIT_COUNT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [UNITS-1:0] unit_raw,
  output logic [UNITS-1:0] level,
  output logic [UNITS-1:0] rise,
  output logic [UNITS-1:0] fall
);

  typedef struct packed {
    logic [UNITS-1:0] meta;
    logic [UNITS-1:0] sync;
    logic [UNITS-1:0] prev;
  } sense_state_type;

  sense_state_type state_reg;
  sense_state_type state_next;

  always_comb begin
    state_next = state_reg;
    // The first stage feeds only the second stage
    state_next.meta = unit_raw;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_unit
      // Only one of the two can be true for any one change of level
      assign rise[u] = state_reg.sync[u] & ~state_reg.prev[u];
      assign fall[u] = ~state_reg.sync[u] & state_reg.prev[u];
    end
  endgenerate

  assign level = state_reg.sync;

endmodule

// File: hw/logic_unit_flags.sv
// Purpose: edge flags, output image and unit 0 input and function select for four logic units
// Assumes: core register port on core_clk; unit inputs and outputs asynchronous to it
// Notes: read data is registered and answers one cycle after the read strobe;
// asynchronous unit inputs are synchronised before any logic reads them,
// so a pin change reaches the output image four edges later
`timescale 1ns/1ps
module logic_unit_flags #(
  parameter int UNITS = logic_unit_pkg::UNIT_COUNT,
  parameter int SOURCES = logic_unit_pkg::SOURCE_COUNT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic_unit_pkg::sfr_req_type sfr_req,
  output logic_unit_pkg::sfr_rsp_type sfr_rsp,
  input wire logic [UNITS-1:0] unit_enable,
  input wire logic [2*UNITS-1:0] edge_irq_enable,
  input wire logic [SOURCES-1:0] unit0_sources,
  input wire logic unit0_carry_in,
  input wire logic [UNITS-1:1] other_unit_out,
  output logic [logic_unit_pkg::SELECT_WIDTH-1:0] unit0_input_a_select,
  output logic [logic_unit_pkg::SELECT_WIDTH-1:0] unit0_input_b_select,
  output logic [UNITS-1:0] unit_output_level,
  output logic edge_irq_request
);

  localparam int SW = logic_unit_pkg::SELECT_WIDTH;

  typedef struct packed {
    logic [7:0] input_select;
    logic [7:0] truth_table;
    logic [2*UNITS-1:0] edge_flags;
    logic [7:0] rdata;
    logic rbit;
    logic rvalid;
    // Two-stage synchronisers for the asynchronous unit inputs
    logic [SOURCES-1:0] src_meta;
    logic [SOURCES-1:0] src_sync;
    logic carry_meta;
    logic carry_sync;
    logic [UNITS-1:1] other_meta;
    logic [UNITS-1:1] other_sync;
  } flags_state_type;

  flags_state_type state_reg;
  flags_state_type state_next;

  // Decoded accesses
  logic page_hit;
  logic sel_input_select;
  logic sel_truth_table;
  logic sel_output_state;
  logic sel_edge_flags;
  logic bit_hit;
  logic [2:0] bit_index;

  // Unit 0 datapath
  logic [SW-1:0] sel_a;
  logic [SW-1:0] sel_b;
  logic input_a;
  logic input_b;
  logic [2:0] table_index;
  logic unit0_lut;
  logic [UNITS-1:0] unit_raw;

  // Synchronised copies of the asynchronous unit inputs
  logic [SOURCES-1:0] sources_sync;
  logic carry_sync;
  logic [UNITS-1:1] others_sync;

  // Byte writes that land in a register this cycle
  logic write_input_select;
  logic write_truth_table;

  // Per-flag software access and next value
  logic [2*UNITS-1:0] flag_byte_write;
  logic [2*UNITS-1:0] flag_bit_write;
  logic [2*UNITS-1:0] flag_sw_write;
  logic [2*UNITS-1:0] flag_sw_value;
  logic [2*UNITS-1:0] flag_next;

  // Edge detector results
  logic [UNITS-1:0] sync_level;
  logic [UNITS-1:0] rise;
  logic [UNITS-1:0] fall;
  logic [2*UNITS-1:0] edge_set;
  logic [7:0] output_image;
  logic [7:0] flag_image;

  assign page_hit = (sfr_req.page == logic_unit_pkg::REG_PAGE);
  assign bit_index = sfr_req.bit_addr[2:0];
  assign write_input_select = sfr_req.we && sel_input_select;
  assign write_truth_table = sfr_req.we && sel_truth_table;

  always_comb begin
    sel_input_select = 1'b0;
    sel_truth_table = 1'b0;
    sel_output_state = 1'b0;
    sel_edge_flags = 1'b0;
    if (!page_hit) begin
      sel_edge_flags = 1'b0;
    end else if (sfr_req.addr == logic_unit_pkg::UNIT0_INPUT_SELECT_ADDR) begin
      sel_input_select = 1'b1;
    end else if (sfr_req.addr == logic_unit_pkg::UNIT0_TRUTH_TABLE_ADDR) begin
      sel_truth_table = 1'b1;
    end else if (sfr_req.addr == logic_unit_pkg::OUTPUT_STATE_ADDR) begin
      sel_output_state = 1'b1;
    end else if (sfr_req.addr == logic_unit_pkg::EDGE_FLAG_ADDR) begin
      sel_edge_flags = 1'b1;
    end
  end

  // Bit addresses e8..ef reach the eight flags one at a time
  assign bit_hit = page_hit
    && (sfr_req.bit_addr[7:logic_unit_pkg::BIT_GROUP_LSB] == logic_unit_pkg::EDGE_FLAG_BIT_GROUP);

  // Unit 0 input multiplexers, steered by the stored selectors
  assign sel_a = state_reg.input_select[logic_unit_pkg::INPUT_A_LSB +: SW];
  assign sel_b = state_reg.input_select[logic_unit_pkg::INPUT_B_LSB +: SW];
  assign input_a = sources_sync[sel_a];
  assign input_b = sources_sync[sel_b];

  // The truth table and the enables read only the second stage
  assign sources_sync = state_reg.src_sync;
  assign carry_sync = state_reg.carry_sync;
  assign others_sync = state_reg.other_sync;

  // Truth table: A is the most significant select line, carry-in the least
  assign table_index = {input_a, input_b, carry_sync};
  // With e4 the carry picks A when high and B when low
  assign unit0_lut = state_reg.truth_table[table_index];

  // A disabled unit reads low; after the one falling edge that disabling a high unit gives, it produces no new edges
  assign unit_raw = {others_sync, unit0_lut} & unit_enable;

  unit_edge_sense #(
    .UNITS(UNITS)
  ) edge_sense (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .unit_raw(unit_raw),
    .level(sync_level),
    .rise(rise),
    .fall(fall)
  );

  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_flag_map
      assign edge_set[u*logic_unit_pkg::FLAGS_PER_UNIT + logic_unit_pkg::RISING_FLAG_OFFSET] =
        rise[u];
      assign edge_set[u*logic_unit_pkg::FLAGS_PER_UNIT + logic_unit_pkg::FALLING_FLAG_OFFSET] =
        fall[u];
    end
  endgenerate

  genvar f;
  generate
    for (f = 0; f < 2*UNITS; f++) begin : g_flag_bit
      assign flag_byte_write[f] = sfr_req.we && sel_edge_flags;
      assign flag_bit_write[f] = sfr_req.bit_we && bit_hit && (bit_index == 3'(f));
      assign flag_sw_write[f] = flag_byte_write[f] || flag_bit_write[f];
      // A bit write wins over a byte write for its own flag
      assign flag_sw_value[f] = flag_bit_write[f] ? sfr_req.bit_value : sfr_req.wdata[f];
      // Hardware set wins over a clear in the same cycle, so no edge is lost
      assign flag_next[f] = (flag_sw_write[f] ? flag_sw_value[f] : state_reg.edge_flags[f])
        | edge_set[f];
    end
  endgenerate

  // Upper bits of the output image are reserved and read zero
  always_comb begin
    output_image = 8'h00;
    output_image[UNITS-1:0] = sync_level;
  end

  always_comb begin
    flag_image = 8'h00;
    flag_image[2*UNITS-1:0] = state_reg.edge_flags;
  end

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;

    if (write_input_select) begin
      state_next.input_select = sfr_req.wdata;
    end
    if (write_truth_table) begin
      state_next.truth_table = sfr_req.wdata;
    end
    // Writes to the output image fall away
    state_next.edge_flags = flag_next;
    // The first stage of each synchroniser feeds only the second
    state_next.src_meta = unit0_sources;
    state_next.src_sync = state_reg.src_meta;
    state_next.carry_meta = unit0_carry_in;
    state_next.carry_sync = state_reg.carry_meta;
    state_next.other_meta = other_unit_out;
    state_next.other_sync = state_reg.other_meta;

    if (sfr_req.re) begin
      state_next.rvalid = 1'b1;
      if (sel_input_select) begin
        state_next.rdata = state_reg.input_select;
      end else if (sel_truth_table) begin
        state_next.rdata = state_reg.truth_table;
      end else if (sel_output_state) begin
        state_next.rdata = output_image;
      end else if (sel_edge_flags) begin
        state_next.rdata = flag_image;
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    if (sfr_req.bit_re) begin
      state_next.rvalid = 1'b1;
      state_next.rbit = bit_hit ? flag_image[bit_index] : 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg.input_select <= logic_unit_pkg::INPUT_SELECT_RESET;
      state_reg.truth_table <= logic_unit_pkg::TRUTH_TABLE_RESET;
      state_reg.edge_flags <= logic_unit_pkg::EDGE_FLAG_RESET[2*UNITS-1:0];
      state_reg.rdata <= logic_unit_pkg::READ_DATA_RESET;
      state_reg.rbit <= 1'b0;
      state_reg.rvalid <= 1'b0;
      state_reg.src_meta <= '0;
      state_reg.src_sync <= '0;
      state_reg.carry_meta <= 1'b0;
      state_reg.carry_sync <= 1'b0;
      state_reg.other_meta <= '0;
      state_reg.other_sync <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign sfr_rsp.rdata = state_reg.rdata;
  assign sfr_rsp.rbit = state_reg.rbit;
  assign sfr_rsp.rvalid = state_reg.rvalid;
  assign unit0_input_a_select = sel_a;
  assign unit0_input_b_select = sel_b;
  assign unit_output_level = sync_level;
  // Level request; it stays up until software clears the enabled flag or its enable bit
  assign edge_irq_request = |(state_reg.edge_flags & edge_irq_enable);

endmodule

// File: dv/logic_unit_flags_assertions.sv
// Purpose: port-level checks of the logic unit flag and select block
// Assumes: one clock, synchronous active-high reset
// Notes: flags are seen only through the request line
`timescale 1ns/1ps
module logic_unit_flags_assertions #(
  parameter int UNITS = 4,
  parameter int SOURCES = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic_unit_pkg::sfr_req_type sfr_req,
  input wire logic_unit_pkg::sfr_rsp_type sfr_rsp,
  input wire logic [UNITS-1:0] unit_enable,
  input wire logic [2*UNITS-1:0] edge_irq_enable,
  input wire logic [SOURCES-1:0] unit0_sources,
  input wire logic unit0_carry_in,
  input wire logic [UNITS-1:1] other_unit_out,
  input wire logic [logic_unit_pkg::SELECT_WIDTH-1:0] unit0_input_a_select,
  input wire logic [logic_unit_pkg::SELECT_WIDTH-1:0] unit0_input_b_select,
  input wire logic [UNITS-1:0] unit_output_level,
  input wire logic edge_irq_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = ce && sfr_req.page == 8'h20;
  property p_sel;
    hit && sfr_req.we && sfr_req.addr == 8'h84 |=>
      {unit0_input_a_select, unit0_input_b_select} == $past(sfr_req.wdata);
  endproperty
  a_sel: assert property (p_sel) else $error("selectors not loaded");
  property p_reset;
    disable iff (1'b0) rst |=> unit0_input_a_select == 4'h0 && unit0_input_b_select == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("selectors not cleared");
  property p_read;
    hit && sfr_req.re && sfr_req.addr == 8'hd1 |=>
      sfr_rsp.rvalid && sfr_rsp.rdata == {4'h0, $past(unit_output_level)};
  endproperty
  a_read: assert property (p_read) else $error("output state read wrong");
  property p_edge(int k);
    ce && (k % 2 ? $rose(unit_output_level[k/2]) : $fell(unit_output_level[k/2]))
      && edge_irq_enable[k] |=> edge_irq_request || !edge_irq_enable[k];
  endproperty
  for (genvar k = 0; k < 2*UNITS; k++) begin : g_flag
    a_edge: assert property (p_edge(k)) else $error("edge set no flag");
  end
  property p_hold;
    edge_irq_request && !sfr_req.we && !sfr_req.bit_we |=>
      edge_irq_request || $changed(edge_irq_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("flag cleared by itself");
  property p_quiet;
    edge_irq_enable == '0 |-> !edge_irq_request;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request with no enable");
  property p_level(int u);
    (ce && unit_enable[u])[*5] |-> unit_output_level[u] == $past(other_unit_out[u], 4);
  endproperty
  for (genvar u = 1; u < UNITS; u++) begin : g_sync
    a_level: assert property (p_level(u)) else $error("level not synchronised");
  end
  c_rise: cover property (ce && $rose(unit_output_level[0]));
  c_req: cover property ($rose(edge_irq_request));
  c_read: cover property (sfr_rsp.rvalid);
endmodule
bind logic_unit_flags logic_unit_flags_assertions #(.UNITS(UNITS), .SOURCES(SOURCES)) i_chk (
  .core_clk(core_clk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .sfr_rsp(sfr_rsp),
  .unit_enable(unit_enable), .edge_irq_enable(edge_irq_enable),
  .unit0_sources(unit0_sources), .unit0_carry_in(unit0_carry_in),
  .other_unit_out(other_unit_out), .unit0_input_a_select(unit0_input_a_select),
  .unit0_input_b_select(unit0_input_b_select), .unit_output_level(unit_output_level),
  .edge_irq_request(edge_irq_request));

// File: dv/sfr_core_model.sv
// Purpose: stand-in for the processor core on the register port
// Assumes: access taken on a rising edge, read answer one cycle later
// Notes: released page, address and data lines are inverted and strobes dropped so a stale value cannot pass
`timescale 1ns/1ps
module sfr_core_model (
  input wire logic core_clk,
  input wire logic_unit_pkg::sfr_rsp_type sfr_rsp,
  output logic_unit_pkg::sfr_req_type sfr_req
);
  initial sfr_req = '0;
  // k holds the strobes {bit_re, bit_we, re, we}
  task automatic access(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic b, output logic v);
    @(posedge core_clk);
    sfr_req <= '{8'h20, a, d, k[0], k[1], a, d[0], k[2], k[3]};
    @(posedge core_clk);
    sfr_req <= '{8'hdf, ~a, ~d, 1'b0, 1'b0, ~a, ~d[0], 1'b0, 1'b0};
    #1;
    q = sfr_rsp.rdata;
    b = sfr_rsp.rbit;
    v = sfr_rsp.rvalid;
  endtask
endmodule

// File: dv/logic_unit_flags_test.sv
// Purpose: register-level test of the logic unit flag and select block
// Assumes: core model drives the register port
// Notes: unit 0 is steered through its truth table
`timescale 1ns/1ps
module logic_unit_flags_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic_unit_pkg::sfr_req_type sfr_req;
  logic_unit_pkg::sfr_rsp_type sfr_rsp;
  logic [3:0] unit_enable = 4'hf;
  logic [7:0] edge_irq_enable = 8'h00;
  logic [15:0] unit0_sources = 16'h0000;
  logic unit0_carry_in = 1'b0;
  logic [3:1] other_unit_out = 3'h0;
  logic [3:0] sel_a, sel_b, level;
  logic irq, b, v;
  logic [7:0] q, fn;
  logic [7:0] regs [5] = '{8'h84, 8'haf, 8'hd1, 8'he8, 8'h85};
  int n_fail = 0;
  int n_tests = 0;
  logic_unit_flags i_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .sfr_req(sfr_req),
    .sfr_rsp(sfr_rsp), .unit_enable(unit_enable), .edge_irq_enable(edge_irq_enable),
    .unit0_sources(unit0_sources), .unit0_carry_in(unit0_carry_in),
    .other_unit_out(other_unit_out), .unit0_input_a_select(sel_a),
    .unit0_input_b_select(sel_b), .unit_output_level(level), .edge_irq_request(irq));
  sfr_core_model i_core (.core_clk(core_clk), .sfr_rsp(sfr_rsp), .sfr_req(sfr_req));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_core.access(4'h2, a, 8'h00, q, b, v);
    chk({7'h0, v}, 8'h01);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_core.access(4'h1, a, d, q, b, v);
  endtask
  task automatic settle();
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (regs[k]) rd(regs[k], 8'h00);
    wr(8'h84, 8'h29);
    chk({sel_a, sel_b}, 8'h29);
    rd(8'h84, 8'h29);
    ce <= 1'b0;
    wr(8'h84, 8'h55);
    ce <= 1'b1;
    rd(8'h84, 8'h29);
    $display("reset and selectors done");
    // A is source 2, B is source 9; all other sources sit high to expose a wrong pick
    for (int i = 0; i < 16; i++) begin
      fn = i[3] ? 8'h96 : 8'he4;
      if (i[2:0] == 3'h0) wr(8'haf, fn);
      @(posedge core_clk);
      unit0_sources <= 16'hfdfb | {6'h0, i[1], 6'h0, i[2], 2'h0};
      unit0_carry_in <= i[0];
      settle();
      chk({7'h0, level[0]}, {7'h0, fn[i[2:0]]});
    end
    $display("truth table done");
    wr(8'haf, 8'h00);
    settle();
    wr(8'he8, 8'h00);
    rd(8'he8, 8'h00);
    edge_irq_enable <= 8'haa;
    unit_enable <= 4'hd;
    wr(8'haf, 8'hff);
    other_unit_out <= 3'h7;
    settle();
    rd(8'hd1, 8'h0d);
    rd(8'he8, 8'ha2);
    unit_enable <= 4'hf;
    settle();
    rd(8'he8, 8'haa);
    wr(8'hd1, 8'hf0);
    rd(8'hd1, 8'h0f);
    wr(8'he8, 8'h00);
    edge_irq_enable <= 8'h55;
    wr(8'haf, 8'h00);
    other_unit_out <= 3'h0;
    settle();
    rd(8'he8, 8'h55);
    i_core.access(4'h4, 8'hea, 8'h00, q, b, v);
    rd(8'he8, 8'h51);
    i_core.access(4'h8, 8'he8, 8'h00, q, b, v);
    chk({7'h0, b}, 8'h01);
    edge_irq_enable <= 8'h04;
    repeat (2) @(posedge core_clk);
    chk({7'h0, irq}, 8'h00);
    edge_irq_enable <= 8'h01;
    repeat (2) @(posedge core_clk);
    chk({7'h0, irq}, 8'h01);
    $display("edge flags done");
    results();
  end
endmodule
